// file: core/sysctl_exec_defs.vh
// Constants for the system-control and block-copy execution unit
`ifndef SYSCTL_EXEC_DEFS_VH
`define SYSCTL_EXEC_DEFS_VH

// ************************************************************
// Operation codes presented on i_op
// ************************************************************
`define OP_NOP 4'h0
`define OP_SLEEP 4'h1
`define OP_TRAP 4'h2
`define OP_RTE 4'h3
`define OP_LDC_IMM 4'h4
`define OP_LDC_REG 4'h5
`define OP_LDC_MEM 4'h6
`define OP_STC_REG 4'h7
`define OP_STC_MEM 4'h8
`define OP_FLAGS_AND_IMMEDIATE 4'h9
`define OP_ORC 4'hA
`define OP_FLAGS_XOR_IMMEDIATE 4'hB
`define OP_COPY_B 4'hC
`define OP_COPY_W 4'hD

// ************************************************************
// Memory addressing modes presented on i_amode
// ************************************************************
`define AM_IND 3'h0
`define AM_D16 3'h1
`define AM_D24 3'h2
`define AM_STEP 3'h3
`define AM_A16 3'h4
`define AM_A24 3'h5

// ************************************************************
// Execution states per instruction
// ************************************************************
`define ST_SHORT 16'h0002
`define ST_TRAP_NRM 16'h000E
`define ST_TRAP_ADV 16'h0010
`define ST_RTE 16'h000A
`define ST_MEM_IND 16'h0006
`define ST_MEM_D16 16'h0008
`define ST_MEM_D24 16'h000C
`define ST_MEM_STEP 16'h0008
`define ST_MEM_A16 16'h0008
`define ST_MEM_A24 16'h000A
`define ST_COPY_BASE 16'h0008
`define ST_LOAD_ADJ 16'h0002

// ************************************************************
// Instruction lengths in bytes
// ************************************************************
`define LEN_2 24'h000002
`define LEN_4 24'h000004
`define LEN_6 24'h000006
`define LEN_8 24'h000008
`define LEN_10 24'h00000A

// ************************************************************
// Flag layout, reset values, stack and vector constants
// ************************************************************
`define CCR_MASK_BIT 7
`define CCR_RST 8'h80
`define PC_RST 24'h000000
`define SP_RST 24'h00FF80
`define TRAP_VEC_BASE 24'h000010
`define PTR_STEP 32'h00000002
`define SP_STEP_NRM 24'h000004
`define SP_STEP_ADV 24'h000006
`define WORD_STEP 24'h000002

`endif

// file: core/state_timer.v
// Down-counter that measures the execution states of one instruction
module state_timer (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // Load and status
  input wire i_load,
  input wire [15:0] i_value,
  output wire o_zero
);

  reg [15:0] cnt_ff;
  reg [15:0] nxt_cnt;

  // Reload wins over the running count
  always @* begin
    nxt_cnt = cnt_ff;
    if (i_load) begin
      nxt_cnt = i_value;
    end else if (cnt_ff != 16'h0000) begin
      nxt_cnt = cnt_ff - 16'h0001;
    end
  end

  // Counter register
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign o_zero = (cnt_ff == 16'h0000);

endmodule // state_timer

// file: core/sysctl_exec.v
// Execution unit for flag, trap, return, sleep and block-copy instructions
// What this block does
// RULE1 - Trap pushes program counter then flags, sets mask bit, jumps; 14/16 states.
// RULE2 - Exception return pops flags then program counter, restoring every flag.
// RULE3 - Post-increment flag load reads word at pointer, then pointer plus two.
// RULE4 - Flag load: 24-bit displacement 10 bytes, 16-bit displacement 6 bytes.
// RULE5 - Flag store, 16-bit displacement: word write, 6 bytes, flags untouched.
// RULE6 - Pre-decrement flag store subtracts two from pointer, then writes there.
// RULE7 - Block copy moves bytes source to destination, bumps pointers, counts down.
// RULE8 - Zero count at start copies nothing and leaves all flags alone.
// RULE9 - Byte form counts low half, word form full count; 8 plus 4 per byte.
// RULE10 - State counts assume code and operands sit in on-chip memory.
// RULE11 - Immediate AND, OR, XOR on flags write every flag in 2 states.
// RULE12 - Sleep enters power-down, flags kept; no-op only advances by two.
`include "sysctl_exec_defs.vh"
module sysctl_exec (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // Decoded instruction
  input wire i_start,
  input wire [3:0] i_op,
  input wire [2:0] i_amode,
  input wire i_adv_mode,
  input wire [7:0] i_imm,
  input wire [23:0] i_disp,
  input wire [31:0] i_ptr,
  input wire [7:0] i_rs8,
  input wire [1:0] i_trap_num,
  input wire [15:0] i_count,
  input wire [23:0] i_src,
  input wire [23:0] i_dst,
  input wire i_wake,
  // On-chip memory, read data valid in the cycle of the request
  input wire [15:0] i_mem_rdata,
  output reg o_mem_req,
  output reg o_mem_we,
  output reg o_mem_byte,
  output reg [23:0] o_mem_addr,
  output reg [15:0] o_mem_wdata,
  // Status and architectural results
  output reg o_busy,
  output reg o_done,
  output reg o_sleep,
  output reg [23:0] o_pc,
  output reg [23:0] o_sp,
  output reg [7:0] o_ccr,
  output reg [31:0] o_ptr,
  output reg o_ptr_we,
  output reg [7:0] o_rd8,
  output reg o_rd8_we,
  output reg [23:0] o_src,
  output reg [23:0] o_dst,
  output reg [15:0] o_count,
  output reg o_copy_we
);

  // ************************************************************
  // Sequencer states
  // ************************************************************
  localparam S_IDLE = 3'h0;
  localparam S_ACC = 3'h1;
  localparam S_CPR = 3'h2;
  localparam S_CPC = 3'h3;
  localparam S_CPW = 3'h4;
  localparam S_CPN = 3'h5;
  localparam S_HOLD = 3'h6;

  reg [2:0] state_ff;
  reg [2:0] step_ff;
  reg phase_ff;
  reg [3:0] op_ff;
  reg [2:0] am_ff;
  reg adv_ff;
  reg [7:0] imm_ff;
  reg [23:0] disp_ff;
  reg [31:0] ptr_ff;
  reg [7:0] rs8_ff;
  reg [1:0] tnum_ff;
  reg [23:0] tmp_pc_ff;
  reg [7:0] tmp_ccr_ff;
  reg [7:0] byte_ff;
  reg wake_meta_ff;
  reg wake_ff;
  reg tmr_load;
  reg [15:0] tmr_value;
  wire tmr_zero;

  // Wake is a pin; two stages before use
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      wake_meta_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else begin
      wake_meta_ff <= i_wake;
      wake_ff <= wake_meta_ff;
    end
  end

  state_timer u_timer (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_load(tmr_load),
    .i_value(tmr_value),
    .o_zero(tmr_zero)
  );

  // ************************************************************
  // Decode of the instruction being accepted
  // ************************************************************
  reg [15:0] n_states;
  always @* begin
    case (i_op)
      `OP_TRAP: n_states = i_adv_mode ? `ST_TRAP_ADV : `ST_TRAP_NRM; // [RULE1]
      `OP_RTE: n_states = `ST_RTE;
      `OP_LDC_MEM, `OP_STC_MEM: begin
        case (i_amode)
          `AM_IND: n_states = `ST_MEM_IND;
          `AM_D16: n_states = `ST_MEM_D16;
          `AM_D24: n_states = `ST_MEM_D24;
          `AM_STEP: n_states = `ST_MEM_STEP;
          `AM_A16: n_states = `ST_MEM_A16;
          default: n_states = `ST_MEM_A24;
        endcase
      end
      `OP_COPY_B, `OP_COPY_W: n_states = `ST_COPY_BASE; // [RULE9]
      default: n_states = `ST_SHORT; // [RULE11] [RULE12]
    endcase
  end

  // Timer counts every state, assuming single-cycle on-chip access [RULE10]
  wire copy_zero = (i_op == `OP_COPY_B) ? (i_count[7:0] == 8'h00) :
    (i_count == 16'h0000); // [RULE9]
  wire accept = i_start && (state_ff == S_IDLE) && !o_sleep;

  // ************************************************************
  // Addresses and memory steps of the current instruction
  // ************************************************************
  wire [23:0] ptr24 = ptr_ff[23:0];
  wire [23:0] d16_ext = {{8{disp_ff[15]}}, disp_ff[15:0]};
  wire [23:0] vec_off = adv_ff ? {20'h00000, tnum_ff, 2'b00} :
    {21'h000000, tnum_ff, 1'b0};
  wire [23:0] vec_addr = `TRAP_VEC_BASE + vec_off;
  reg [23:0] ea;
  reg [23:0] acc_addr;
  reg acc_we;
  reg [15:0] acc_wdata;
  reg acc_last;
  reg [23:0] inst_len;

  // Effective address and instruction length for flag load and store
  always @* begin
    ea = ptr24;
    inst_len = `LEN_4;
    case (am_ff)
      `AM_D16: begin
        ea = ptr24 + d16_ext;
        inst_len = `LEN_6; // [RULE4] [RULE5]
      end
      `AM_D24: begin
        ea = ptr24 + disp_ff;
        inst_len = `LEN_10; // [RULE4]
      end
      `AM_STEP: begin
        if (op_ff == `OP_STC_MEM) begin
          ea = ptr24 - `WORD_STEP; // [RULE6]
        end
      end
      `AM_A16: begin
        ea = d16_ext;
        inst_len = `LEN_6;
      end
      `AM_A24: begin
        ea = disp_ff;
        inst_len = `LEN_8;
      end
      default: ea = ptr24;
    endcase
  end

  // Access list; stack grows down, program counter goes at higher addresses than the flags
  always @* begin
    acc_addr = ea;
    acc_we = 1'b0;
    acc_wdata = {8'h00, o_ccr};
    acc_last = 1'b1;
    case (op_ff)
      `OP_TRAP: begin
        acc_we = 1'b1;
        acc_last = 1'b0;
        case ({adv_ff, step_ff})
          4'h0: begin
            acc_addr = o_sp - `WORD_STEP;
            acc_wdata = o_pc[15:0];
          end
          4'h1: acc_addr = o_sp - `SP_STEP_NRM;
          4'h8: begin
            acc_addr = o_sp - `SP_STEP_NRM;
            acc_wdata = {8'h00, o_pc[23:16]};
          end
          4'h9: begin
            acc_addr = o_sp - `WORD_STEP;
            acc_wdata = o_pc[15:0];
          end
          4'hA: acc_addr = o_sp - `SP_STEP_ADV;
          4'hB: begin
            acc_we = 1'b0;
            acc_addr = vec_addr;
          end
          default: begin
            acc_we = 1'b0;
            acc_last = 1'b1;
            acc_addr = adv_ff ? vec_addr + `WORD_STEP : vec_addr;
          end
        endcase
      end
      `OP_RTE: begin
        acc_addr = o_sp + {20'h00000, step_ff, 1'b0};
        acc_last = adv_ff ? (step_ff == 3'h2) : (step_ff == 3'h1);
      end
      `OP_STC_MEM: acc_we = 1'b1; // [RULE5] [RULE6]
      default: acc_we = 1'b0; // [RULE3]
    endcase
  end

  // ************************************************************
  // Sequencer, memory port and architectural state
  // ************************************************************
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      state_ff <= S_IDLE;
      step_ff <= 3'h0;
      phase_ff <= 1'b0;
      op_ff <= `OP_NOP;
      am_ff <= `AM_IND;
      adv_ff <= 1'b0;
      imm_ff <= 8'h00;
      disp_ff <= 24'h000000;
      ptr_ff <= 32'h00000000;
      rs8_ff <= 8'h00;
      tnum_ff <= 2'b00;
      tmp_pc_ff <= `PC_RST;
      tmp_ccr_ff <= `CCR_RST;
      byte_ff <= 8'h00;
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_byte <= 1'b0;
      o_mem_addr <= 24'h000000;
      o_mem_wdata <= 16'h0000;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_sleep <= 1'b0;
      o_pc <= `PC_RST;
      o_sp <= `SP_RST;
      o_ccr <= `CCR_RST;
      o_ptr <= 32'h00000000;
      o_ptr_we <= 1'b0;
      o_rd8 <= 8'h00;
      o_rd8_we <= 1'b0;
      o_src <= 24'h000000;
      o_dst <= 24'h000000;
      o_count <= 16'h0000;
      o_copy_we <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_ptr_we <= 1'b0;
      o_rd8_we <= 1'b0;
      o_copy_we <= 1'b0;
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      // Wake only leaves power-down; it never interrupts an instruction
      if (wake_ff) begin
        o_sleep <= 1'b0;
      end
      case (state_ff)
        S_IDLE: begin
          if (accept) begin
            op_ff <= i_op;
            am_ff <= i_amode;
            adv_ff <= i_adv_mode;
            imm_ff <= i_imm;
            disp_ff <= i_disp;
            ptr_ff <= i_ptr;
            rs8_ff <= i_rs8;
            tnum_ff <= i_trap_num;
            o_src <= i_src;
            o_dst <= i_dst;
            o_count <= i_count;
            step_ff <= 3'h0;
            phase_ff <= 1'b0;
            o_busy <= 1'b1;
            if (i_op == `OP_TRAP || i_op == `OP_RTE ||
                i_op == `OP_LDC_MEM || i_op == `OP_STC_MEM) begin
              state_ff <= S_ACC;
            end else if ((i_op == `OP_COPY_B || i_op == `OP_COPY_W) &&
                         !copy_zero) begin
              state_ff <= S_CPR; // [RULE7]
            end else begin
              state_ff <= S_HOLD; // [RULE8]
            end
          end
        end
        S_ACC: begin
          if (!phase_ff) begin
            o_mem_req <= 1'b1;
            o_mem_we <= acc_we;
            o_mem_byte <= 1'b0;
            o_mem_addr <= acc_addr;
            o_mem_wdata <= acc_wdata;
            phase_ff <= 1'b1;
          end else begin
            phase_ff <= 1'b0;
            step_ff <= step_ff + 3'h1;
            // Read data is taken in the cycle the request is visible
            if (!o_mem_we) begin
              if (op_ff == `OP_RTE && step_ff == 3'h0) begin
                tmp_ccr_ff <= i_mem_rdata[7:0]; // [RULE2]
              end else if (acc_last) begin
                tmp_pc_ff[15:0] <= i_mem_rdata;
                tmp_ccr_ff <= (op_ff == `OP_LDC_MEM) ? i_mem_rdata[7:0] :
                  tmp_ccr_ff;
              end else begin
                tmp_pc_ff[23:16] <= i_mem_rdata[7:0];
              end
              if (acc_last && !adv_ff) begin
                tmp_pc_ff[23:16] <= 8'h00;
              end
            end
            if (acc_last) begin
              state_ff <= S_HOLD;
            end
          end
        end
        S_CPR: begin
          o_mem_req <= 1'b1;
          o_mem_byte <= 1'b1;
          o_mem_addr <= o_src;
          state_ff <= S_CPC;
        end
        S_CPC: begin
          byte_ff <= i_mem_rdata[7:0];
          o_mem_req <= 1'b1;
          o_mem_we <= 1'b1;
          o_mem_byte <= 1'b1;
          o_mem_addr <= o_dst;
          o_mem_wdata <= {8'h00, i_mem_rdata[7:0]};
          state_ff <= S_CPW;
        end
        S_CPW: begin
          state_ff <= S_CPN;
        end
        S_CPN: begin
          // Pointers step after every byte; byte form keeps count top half
          o_src <= o_src + 24'h000001; // [RULE7]
          o_dst <= o_dst + 24'h000001;
          if (op_ff == `OP_COPY_B) begin
            o_count[7:0] <= o_count[7:0] - 8'h01; // [RULE9]
          end else begin
            o_count <= o_count - 16'h0001;
          end
          if ((op_ff == `OP_COPY_B && o_count[7:0] == 8'h01) ||
              (op_ff == `OP_COPY_W && o_count == 16'h0001)) begin
            state_ff <= S_HOLD;
          end else begin
            state_ff <= S_CPR;
          end
        end
        S_HOLD: begin
          if (tmr_zero) begin
            state_ff <= S_IDLE;
            o_busy <= 1'b0;
            o_done <= 1'b1;
            o_pc <= o_pc + `LEN_2; // [RULE12]
            case (op_ff)
              `OP_SLEEP: o_sleep <= 1'b1; // [RULE12]
              `OP_TRAP: begin
                o_pc <= tmp_pc_ff; // [RULE1]
                o_ccr[`CCR_MASK_BIT] <= 1'b1;
                o_sp <= o_sp - (adv_ff ? `SP_STEP_ADV : `SP_STEP_NRM);
              end
              `OP_RTE: begin
                o_pc <= tmp_pc_ff; // [RULE2]
                o_ccr <= tmp_ccr_ff;
                o_sp <= o_sp + (adv_ff ? `SP_STEP_ADV : `SP_STEP_NRM);
              end
              `OP_LDC_IMM: o_ccr <= imm_ff;
              `OP_LDC_REG: o_ccr <= rs8_ff;
              `OP_LDC_MEM: begin
                o_ccr <= tmp_ccr_ff;
                o_pc <= o_pc + inst_len; // [RULE4]
                if (am_ff == `AM_STEP) begin
                  o_ptr <= ptr_ff + `PTR_STEP; // [RULE3]
                  o_ptr_we <= 1'b1;
                end
              end
              `OP_STC_REG: begin
                o_rd8 <= o_ccr;
                o_rd8_we <= 1'b1;
              end
              `OP_STC_MEM: begin
                o_pc <= o_pc + inst_len; // [RULE5]
                if (am_ff == `AM_STEP) begin
                  o_ptr <= ptr_ff - `PTR_STEP; // [RULE6]
                  o_ptr_we <= 1'b1;
                end
              end
              `OP_FLAGS_AND_IMMEDIATE: o_ccr <= o_ccr & imm_ff; // [RULE11]
              `OP_ORC: o_ccr <= o_ccr | imm_ff;
              `OP_FLAGS_XOR_IMMEDIATE: o_ccr <= o_ccr ^ imm_ff;
              `OP_COPY_B, `OP_COPY_W: begin
                o_pc <= o_pc + `LEN_4; // [RULE8]
                o_copy_we <= 1'b1;
              end
              default: o_ccr <= o_ccr;
            endcase
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // Timer loads at accept, and again with the fixed tail after each copied byte
  always @* begin
    tmr_load = 1'b0;
    tmr_value = n_states - `ST_LOAD_ADJ;
    if (accept) begin
      tmr_load = 1'b1;
    end else if (state_ff == S_CPN) begin
      tmr_load = 1'b1;
      tmr_value = `ST_COPY_BASE - `ST_LOAD_ADJ; // [RULE9]
    end
  end

endmodule // sysctl_exec

// file: verif/sysctl_exec_sva.sv
// Port-level timing and result checks for the execution unit
`include "sysctl_exec_defs.vh"
module sysctl_exec_sva (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Instruction inputs
  input wire logic i_start,
  input wire logic [3:0] i_op,
  input wire logic [2:0] i_amode,
  input wire logic i_adv_mode,
  input wire logic [7:0] i_imm,
  input wire logic [31:0] i_ptr,
  input wire logic [15:0] i_count,
  input wire logic [15:0] i_mem_rdata,
  // Outputs watched
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic o_mem_byte,
  input wire logic [23:0] o_mem_addr,
  input wire logic [15:0] o_mem_wdata,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_sleep,
  input wire logic [23:0] o_pc,
  input wire logic [7:0] o_ccr,
  input wire logic [31:0] o_ptr,
  input wire logic o_ptr_we,
  input wire logic o_copy_we
);
  // Request accepted only when idle and awake
  wire logic take = i_start && !o_busy && !o_sleep;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // ************************************************************
  // Timing and results per instruction
  // ************************************************************
  chk_trap_normal: assert property (
    take && i_op == `OP_TRAP && !i_adv_mode |-> ##14 (o_done && o_ccr[7]))
    else $error("trap normal timing or mask bit wrong");
  chk_trap_adv: assert property (
    take && i_op == `OP_TRAP && i_adv_mode |-> ##16 (o_done && o_ccr[7]))
    else $error("trap advanced timing or mask bit wrong");
  chk_rte_states: assert property (
    take && i_op == `OP_RTE |-> ##2 !o_done [*8] ##1 o_done)
    else $error("exception return timing wrong");
  chk_load_postinc: assert property (
    take && i_op == `OP_LDC_MEM && i_amode == `AM_STEP |->
    ##8 (o_done && o_ptr_we && o_ptr == $past(i_ptr, 8) + 32'h00000002))
    else $error("post-increment pointer wrong");
  chk_store_predec: assert property (
    take && i_op == `OP_STC_MEM && i_amode == `AM_STEP |-> ##2 (o_mem_req
    && o_mem_we && o_mem_addr == $past(i_ptr[23:0], 2) - 24'h000002))
    else $error("pre-decrement store address wrong");
  chk_store_keeps: assert property (
    take && i_op == `OP_STC_MEM && i_amode == `AM_D16 |->
    ##8 (o_done && o_ccr == $past(o_ccr, 8)))
    else $error("flag store changed flags or timing");
  chk_and_flags: assert property (
    take && i_op == `OP_FLAGS_AND_IMMEDIATE |->
    ##2 (o_done && o_ccr == ($past(o_ccr, 2) & $past(i_imm, 2))))
    else $error("flag AND result or timing wrong");
  chk_copy_empty: assert property (
    take && i_op == `OP_COPY_B && i_count[7:0] == 8'h00 |->
    ##1 !o_mem_req [*7] ##1 (o_done && o_copy_we))
    else $error("empty copy moved data or timing wrong");
  chk_copy_write: assert property (
    o_mem_req && !o_mem_we && o_mem_byte |=> (o_mem_req && o_mem_we &&
    o_mem_byte && o_mem_wdata[7:0] == $past(i_mem_rdata[7:0])))
    else $error("copy write does not follow read");
  chk_nop_pc: assert property (
    take && i_op == `OP_NOP |-> ##2 (o_done && o_pc == $past(o_pc) + 24'h2))
    else $error("no-op did not advance by two");
endmodule // sysctl_exec_sva

// file: verif/flag_mem_model.sv
// Behavioural on-chip memory facing the execution unit
module flag_mem_model (
  // Clock
  input wire logic i_core_clk,
  // Access from the unit
  input wire logic i_req,
  input wire logic i_we,
  input wire logic i_byte,
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata
);
  logic [7:0] mem [0:65535];
  logic [15:0] last = 16'hA5A5;
  wire logic [15:0] a = i_addr[15:0];
  // Idle bus shows the inverse of the last value so stale data never passes
  assign o_rdata = !i_req ? ~last :
    i_byte ? {8'h00, mem[a]} : {mem[a], mem[a + 16'h0001]};
  // Writes land at the request edge, words high byte first
  always @(posedge i_core_clk) begin
    if (i_req) begin
      last <= o_rdata;
      if (i_we && i_byte) begin
        mem[a] <= i_wdata[7:0];
      end else if (i_we) begin
        mem[a] <= i_wdata[15:8];
        mem[a + 16'h0001] <= i_wdata[7:0];
      end
    end
  end
endmodule // flag_mem_model

// file: verif/sysctl_exec_bench.sv
// Self-checking bench for the execution unit
`include "sysctl_exec_defs.vh"
module sysctl_exec_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_core_clk, i_rst, i_start, i_adv_mode, i_wake;
  logic [3:0] i_op;
  logic [2:0] i_amode;
  logic [1:0] i_trap_num;
  logic [7:0] i_imm, i_rs8, o_ccr, o_rd8, c;
  logic [15:0] i_count, i_mem_rdata, o_mem_wdata, o_count;
  logic [23:0] i_disp, i_src, i_dst, o_mem_addr, o_pc, o_sp, o_src, o_dst;
  logic [23:0] p, s;
  logic [31:0] i_ptr, o_ptr;
  logic o_mem_req, o_mem_we, o_mem_byte, o_busy, o_done, o_sleep;
  logic o_ptr_we, o_rd8_we, o_copy_we;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  sysctl_exec dut (.i_core_clk, .i_rst, .i_start, .i_op, .i_amode,
    .i_adv_mode, .i_imm, .i_disp, .i_ptr, .i_rs8, .i_trap_num, .i_count,
    .i_src, .i_dst, .i_wake, .i_mem_rdata, .o_mem_req, .o_mem_we,
    .o_mem_byte, .o_mem_addr, .o_mem_wdata, .o_busy, .o_done, .o_sleep,
    .o_pc, .o_sp, .o_ccr, .o_ptr, .o_ptr_we, .o_rd8, .o_rd8_we, .o_src,
    .o_dst, .o_count, .o_copy_we);
  flag_mem_model mem_i (.i_core_clk, .i_req(o_mem_req), .i_we(o_mem_we),
    .i_byte(o_mem_byte), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
    .o_rdata(i_mem_rdata));
  // Clock and hang guard; a full run needs about 1200 cycles
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      finish_test;
    end
  end
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] peekw(input logic [23:0] a);
    return {mem_i.mem[a[15:0]], mem_i.mem[a[15:0] + 16'h0001]};
  endfunction
  // Start one operation and count states until done; only the hang guard bounds the wait
  task run(input logic [3:0] op, input logic [2:0] am);
    @(negedge i_core_clk);
    i_op = op;
    i_amode = am;
    i_start = 1'b1;
    @(negedge i_core_clk);
    i_start = 1'b0;
    n = 1;
    while (o_done !== 1'b1) begin
      @(negedge i_core_clk);
      n++;
    end
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_flags;
    i_imm = 8'h5A;
    run(`OP_LDC_IMM, `AM_IND);
    i_imm = 8'hF0;
    run(`OP_FLAGS_AND_IMMEDIATE, `AM_IND);
    cmp("and flags", 32'h50, o_ccr);
    cmp("and states", 32'h2, n);
    i_imm = 8'h0F;
    run(`OP_ORC, `AM_IND);
    cmp("or flags", 32'h5F, o_ccr);
    i_imm = 8'hFF;
    run(`OP_FLAGS_XOR_IMMEDIATE, `AM_IND);
    cmp("xor flags", 32'hA0, o_ccr);
    cmp("xor states", 32'h2, n);
    i_rs8 = 8'h25;
    run(`OP_LDC_REG, `AM_IND);
    run(`OP_STC_REG, `AM_IND);
    cmp("store to reg", 32'h25, o_rd8);
    cmp("reg store strobe", 32'h1, o_rd8_we);
    $display("flag logic test ended");
  endtask
  task t_sleep;
    p = o_pc;
    c = o_ccr;
    run(`OP_NOP, `AM_IND);
    cmp("nop pc", p + 24'h2, o_pc);
    cmp("nop flags", c, o_ccr);
    cmp("busy at done", 32'h0, o_busy);
    run(`OP_SLEEP, `AM_IND);
    @(negedge i_core_clk);
    cmp("sleep level", 32'h1, o_sleep);
    cmp("sleep flags", c, o_ccr);
    p = o_pc;
    i_op = `OP_NOP;
    i_start = 1'b1;
    repeat (4) @(negedge i_core_clk);
    i_start = 1'b0;
    cmp("start while asleep", p, o_pc);
    i_wake = 1'b1;
    for (int k = 0; k < 10 && o_sleep !== 1'b0; k++) @(negedge i_core_clk);
    i_wake = 1'b0;
    cmp("woken", 32'h0, o_sleep);
    $display("sleep test ended");
  endtask
  task t_ldst;
    mem_i.mem[16'h0200] = 8'h00;
    mem_i.mem[16'h0201] = 8'hC3;
    i_ptr = 32'h00000200;
    run(`OP_LDC_MEM, `AM_STEP);
    cmp("load via pointer", 32'hC3, o_ccr);
    cmp("pointer plus two", 32'h202, o_ptr);
    mem_i.mem[16'h0201] = 8'hA5;
    p = o_pc;
    i_ptr = 32'h00000100;
    i_disp = 24'h000100;
    run(`OP_LDC_MEM, `AM_D24);
    cmp("load d24 flags", 32'hA5, o_ccr);
    cmp("load d24 length", p + 24'hA, o_pc);
    p = o_pc;
    run(`OP_LDC_MEM, `AM_D16);
    cmp("load d16 length", p + 24'h6, o_pc);
    p = o_pc;
    c = o_ccr;
    i_ptr = 32'h00000300;
    i_disp = 24'h000004;
    run(`OP_STC_MEM, `AM_D16);
    cmp("store d16 word", {24'h0, c}, peekw(24'h304));
    cmp("store d16 flags", c, o_ccr);
    cmp("store d16 length", p + 24'h6, o_pc);
    i_ptr = 32'h00000402;
    run(`OP_STC_MEM, `AM_STEP);
    cmp("pre-decrement ptr", 32'h400, o_ptr);
    cmp("pre-decrement word", {24'h0, c}, peekw(24'h400));
    $display("load and store test ended");
  endtask
  task t_trap;
    i_imm = 8'h25;
    run(`OP_LDC_IMM, `AM_IND);
    s = o_sp;
    mem_i.mem[16'h0012] = 8'h12;
    mem_i.mem[16'h0013] = 8'h34;
    i_adv_mode = 1'b0;
    i_trap_num = 2'h1;
    run(`OP_TRAP, `AM_IND);
    cmp("trap states", 32'hE, n);
    cmp("trap vector", 32'h1234, o_pc);
    cmp("trap mask bit", 32'h1, o_ccr[7]);
    cmp("trap stack", s - 24'h4, o_sp);
    cmp("pushed flags", 32'h25, peekw(s - 24'h4));
    run(`OP_RTE, `AM_IND);
    cmp("return states", 32'hA, n);
    cmp("restored flags", 32'h25, o_ccr);
    cmp("restored pc", peekw(s - 24'h2), o_pc);
    cmp("restored stack", s, o_sp);
    mem_i.mem[16'h0019] = 8'h12;
    mem_i.mem[16'h001A] = 8'h34;
    mem_i.mem[16'h001B] = 8'h56;
    i_adv_mode = 1'b1;
    i_trap_num = 2'h2;
    run(`OP_TRAP, `AM_IND);
    cmp("adv trap states", 32'h10, n);
    cmp("adv trap vector", 32'h123456, o_pc);
    cmp("adv trap stack", s - 24'h6, o_sp);
    run(`OP_RTE, `AM_IND);
    cmp("adv restored pc", {peekw(s - 24'h4), peekw(s - 24'h2)},
      {8'h0, o_pc});
    cmp("adv restored flags", 32'h25, o_ccr);
    i_adv_mode = 1'b0;
    $display("trap test ended");
  endtask
  task t_copy;
    for (int j = 0; j < 3; j++) mem_i.mem[16'h0500 + j] = 8'h11 * (j + 1);
    c = o_ccr;
    i_src = 24'h000500;
    i_dst = 24'h000600;
    i_count = 16'hFF03;
    run(`OP_COPY_B, `AM_IND);
    cmp("byte copy states", 32'h14, n);
    cmp("source end", 32'h503, o_src);
    cmp("dest end", 32'h603, o_dst);
    cmp("count end", 32'h0, o_count[7:0]);
    for (int j = 0; j < 3; j++) cmp("copied byte", 8'h11 * (j + 1),
      mem_i.mem[16'h0600 + j]);
    cmp("copy flags", c, o_ccr);
    i_src = 24'h000700;
    i_dst = 24'h000800;
    i_count = 16'h0100;
    run(`OP_COPY_B, `AM_IND);
    cmp("empty copy states", 32'h8, n);
    cmp("empty copy source", 32'h700, o_src);
    run(`OP_COPY_W, `AM_IND);
    cmp("word copy states", 32'h408, n);
    cmp("word copy dest", 32'h900, o_dst);
    $display("block copy test ended");
  endtask
  task finish_test;
    $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Main sequence: all inputs set at time zero, reset for 5 cycles
  initial begin
    {i_rst, i_start, i_adv_mode, i_wake, i_op, i_amode, i_trap_num} = 13'h1000;
    {i_imm, i_rs8, i_count, i_disp, i_src, i_dst, i_ptr} = 136'h0;
    repeat (5) @(negedge i_core_clk);
    i_rst = 1'b0;
    t_flags;
    t_sleep;
    t_ldst;
    t_trap;
    t_copy;
    finish_test;
  end
endmodule // sysctl_exec_bench
bind sysctl_exec sysctl_exec_sva u_sva (.i_core_clk, .i_rst, .i_start, .i_op,
  .i_amode, .i_adv_mode, .i_imm, .i_ptr, .i_count, .i_mem_rdata, .o_mem_req,
  .o_mem_we, .o_mem_byte, .o_mem_addr, .o_mem_wdata, .o_busy, .o_done,
  .o_sleep, .o_pc, .o_ccr, .o_ptr, .o_ptr_we, .o_copy_we);
